// File: hw/tmp_pkg.sv
// constants and state layout for the tiny port pin block
package tmp_pkg;

   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  OFF_MIX_DAT = 8'h00;
   localparam logic [7:0]  OFF_MIX_CTL = 8'h04;
   localparam logic [7:0]  OFF_MIX_PIN = 8'h08;
   localparam logic [7:0]  OFF_IN_PIN  = 8'h0C;
   localparam logic [7:0]  OFF_IN_CTL  = 8'h10;
   localparam logic [7:0]  OFF_BD_DAT  = 8'h14;
   localparam logic [7:0]  OFF_BD_DIR  = 8'h18;
   localparam logic [7:0]  OFF_BD_PIN  = 8'h1C;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int          MIX_B0      = 0;
   localparam int          MIX_B1      = 1;
   localparam int          MIX_LED     = 2;
   localparam int          MIX_B3      = 3;
   localparam int          IN_PU_BIT   = 0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS    = 4;
   localparam int          RST_MIN_PULSE_NS = 50;
   localparam int          RST_MIN_CYC      =
      (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // block state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  mix_dat;
      logic [3:0]  mix_ctl;
      logic [2:0]  mix_pu;
      logic        led_oe;
      logic        in_pu_all;
      logic [7:0]  in_pu;
      logic [7:0]  bd_dat;
      logic [7:0]  bd_dir;
      logic [7:0]  bd_pu;
      logic [2:0]  mix_s1;
      logic [2:0]  mix_s2;
      logic [7:0]  in_s1;
      logic [7:0]  in_s2;
      logic [7:0]  bd_s1;
      logic [7:0]  bd_s2;
      logic        awready;
      logic        wready;
      logic        aw_hold;
      logic        w_hold;
      logic [7:0]  awaddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
   } tmp_state_t;

   localparam tmp_state_t ST_RST = '0;

endpackage : tmp_pkg

// File: hw/tmp_port_pins.sv
// three parallel ports with pull-up control behind an axi4-lite slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.

module tmp_port_pins (
   // clock and resets
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ext_rst_n,
   // axi4-lite write
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // mixed port, bidirectional bits ordered {3,1,0}
   input  wire logic [2:0]        mixed_port_pins_in,
   output      logic [2:0]        mixed_port_pins_out,
   output      logic [2:0]        mixed_port_pins_oe,
   output      logic [2:0]        mixed_port_pins_pu,
   // mixed port bit 2, led sink
   output      logic              led_sink_pin_out,
   output      logic              led_sink_pin_oe,
   output      logic              led_sink_pin_hc,
   // input-only port
   input  wire logic [7:0]        input_port_pins_in,
   input  wire logic [7:0]        input_alt_en,
   output      logic [7:0]        input_port_pins_pu,
   // bidirectional port
   input  wire logic [7:0]        bidir_port_pins_in,
   output      logic [7:0]        bidir_port_pins_out,
   output      logic [7:0]        bidir_port_pins_oe,
   output      logic [7:0]        bidir_port_pins_pu
);

   tmp_pkg::tmp_state_t st_ff;
   tmp_pkg::tmp_state_t nxt_st;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // two-stage synchronisers; stage one feeds stage two only
      nxt_st.mix_s1 = mixed_port_pins_in;
      nxt_st.mix_s2 = st_ff.mix_s1;
      nxt_st.in_s1  = input_port_pins_in;
      nxt_st.in_s2  = st_ff.in_s1;
      nxt_st.bd_s1  = bidir_port_pins_in;
      nxt_st.bd_s2  = st_ff.bd_s1;

      // output-only sink drives from the first cycle out of reset
      nxt_st.led_oe = 1'b1;

      // write channel capture, either order
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_hold = 1'b1;
         nxt_st.wdata  = s_axi_wdata[7:0];
         nxt_st.wstrb0 = s_axi_wstrb[0];
      end

      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // registers are at most one byte wide, only lane 0 matters
      if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid) begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = tmp_pkg::RESP_OKAY;
         case (st_ff.awaddr)
            tmp_pkg::OFF_MIX_DAT: begin
               if (st_ff.wstrb0) begin
                  nxt_st.mix_dat = st_ff.wdata[3:0];
               end
            end
            tmp_pkg::OFF_MIX_CTL: begin
               if (st_ff.wstrb0) begin
                  nxt_st.mix_ctl = st_ff.wdata[3:0];
               end
            end
            tmp_pkg::OFF_IN_CTL: begin
               if (st_ff.wstrb0) begin
                  nxt_st.in_pu_all = st_ff.wdata[tmp_pkg::IN_PU_BIT];
               end
            end
            tmp_pkg::OFF_BD_DAT: begin
               if (st_ff.wstrb0) begin
                  nxt_st.bd_dat = st_ff.wdata;
               end
            end
            tmp_pkg::OFF_BD_DIR: begin
               if (st_ff.wstrb0) begin
                  nxt_st.bd_dir = st_ff.wdata;
               end
            end
            // pin readback registers ignore writes
            tmp_pkg::OFF_MIX_PIN,
            tmp_pkg::OFF_IN_PIN,
            tmp_pkg::OFF_BD_PIN: begin
               nxt_st.bresp = tmp_pkg::RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = tmp_pkg::RESP_SLVERR;
            end
         endcase
      end
      nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
      nxt_st.wready  = !nxt_st.w_hold && !nxt_st.bvalid;

      // read channel, answer one cycle after the address is taken
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = tmp_pkg::RESP_OKAY;
         case (s_axi_araddr)
            tmp_pkg::OFF_MIX_DAT: nxt_st.rdata = {4'h0, st_ff.mix_dat};
            tmp_pkg::OFF_MIX_CTL: nxt_st.rdata = {4'h0, st_ff.mix_ctl};
            // bit 2 has no input path and reads zero
            tmp_pkg::OFF_MIX_PIN: nxt_st.rdata = {4'h0, st_ff.mix_s2[2],
                                  1'b0, st_ff.mix_s2[1:0]};
            tmp_pkg::OFF_IN_PIN:  nxt_st.rdata = st_ff.in_s2;
            tmp_pkg::OFF_IN_CTL:  nxt_st.rdata = {7'h00, st_ff.in_pu_all};
            tmp_pkg::OFF_BD_DAT:  nxt_st.rdata = st_ff.bd_dat;
            tmp_pkg::OFF_BD_DIR:  nxt_st.rdata = st_ff.bd_dir;
            tmp_pkg::OFF_BD_PIN:  nxt_st.rdata = st_ff.bd_s2;
            default: begin
               nxt_st.rdata = 8'h00;
               nxt_st.rresp = tmp_pkg::RESP_SLVERR;
            end
         endcase
      end
      nxt_st.arready = !nxt_st.rvalid;

      // pull-ups registered from the new direction and data
      nxt_st.mix_pu = ~{nxt_st.mix_ctl[tmp_pkg::MIX_B3],
                        nxt_st.mix_ctl[tmp_pkg::MIX_B1],
                        nxt_st.mix_ctl[tmp_pkg::MIX_B0]}
                    & {nxt_st.mix_dat[tmp_pkg::MIX_B3],
                       nxt_st.mix_dat[tmp_pkg::MIX_B1],
                       nxt_st.mix_dat[tmp_pkg::MIX_B0]};
      // alternate function wins over the shared enable
      nxt_st.in_pu = {8{nxt_st.in_pu_all}}
                   & ~input_alt_en;
      nxt_st.bd_pu = ~nxt_st.bd_dir & nxt_st.bd_dat;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // the pin reset clears with no clock so every enable drops at once
   always_ff @(posedge aclk or negedge ext_rst_n) begin
      if (!ext_rst_n) begin
         st_ff <= tmp_pkg::ST_RST;
      end else if (!aresetn) begin
         st_ff <= tmp_pkg::ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready  = st_ff.wready;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rresp   = st_ff.rresp;
   assign s_axi_rdata   = {24'h000000, st_ff.rdata};

   assign mixed_port_pins_out = {st_ff.mix_dat[tmp_pkg::MIX_B3],
                                 st_ff.mix_dat[tmp_pkg::MIX_B1],
                                 st_ff.mix_dat[tmp_pkg::MIX_B0]};
   assign mixed_port_pins_oe  = {st_ff.mix_ctl[tmp_pkg::MIX_B3],
                                 st_ff.mix_ctl[tmp_pkg::MIX_B1],
                                 st_ff.mix_ctl[tmp_pkg::MIX_B0]};
   assign mixed_port_pins_pu  = st_ff.mix_pu;
   assign led_sink_pin_out    = st_ff.mix_dat[tmp_pkg::MIX_LED];
   assign led_sink_pin_oe     = st_ff.led_oe;
   assign led_sink_pin_hc     = st_ff.mix_ctl[tmp_pkg::MIX_LED];
   assign input_port_pins_pu  = st_ff.in_pu;
   assign bidir_port_pins_out = st_ff.bd_dat;
   assign bidir_port_pins_oe  = st_ff.bd_dir;
   assign bidir_port_pins_pu  = st_ff.bd_pu;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_rd_mix_pin;
      s_axi_arvalid && s_axi_arready
         && s_axi_araddr == tmp_pkg::OFF_MIX_PIN;
   endsequence

   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   property p_led_no_input;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      s_rd_mix_pin |=> s_axi_rvalid && s_axi_rdata[2] == 1'b0
                       && s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_led_no_input: assert property (p_led_no_input)
      else $error("led sink bit read back a nonzero input");

   property p_mix_pullup;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      ##1 mixed_port_pins_pu == (~mixed_port_pins_oe & mixed_port_pins_out);
   endproperty
   a_mix_pullup: assert property (p_mix_pullup)
      else $error("mixed port pull-up does not follow direction and data");

   property p_tristate_ext;
      @(posedge aclk)
      !ext_rst_n |-> mixed_port_pins_oe == 3'h0 && !led_sink_pin_oe
                     && bidir_port_pins_oe == 8'h00;
   endproperty
   a_tristate_ext: assert property (p_tristate_ext)
      else $error("pin driven while pin reset is low");

   property p_tristate_sync;
      @(posedge aclk)
      !aresetn |=> mixed_port_pins_oe == 3'h0 && !led_sink_pin_oe
                   && bidir_port_pins_oe == 8'h00
                   && input_port_pins_pu == 8'h00;
   endproperty
   a_tristate_sync: assert property (p_tristate_sync)
      else $error("pin driven after bus reset");

   property p_in_shared;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      $past(input_alt_en) == 8'h00 && $past(aresetn) |->
         input_port_pins_pu == 8'h00 || input_port_pins_pu == 8'hFF;
   endproperty
   a_in_shared: assert property (p_in_shared)
      else $error("input port pull-ups not switched together");

   property p_alt_kills_pu;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      ##1 (input_port_pins_pu & $past(input_alt_en)) == 8'h00;
   endproperty
   a_alt_kills_pu: assert property (p_alt_kills_pu)
      else $error("pull-up left on under an alternate function");

   property p_bd_pullup;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      ##1 bidir_port_pins_pu == (~bidir_port_pins_oe & bidir_port_pins_out);
   endproperty
   a_bd_pullup: assert property (p_bd_pullup)
      else $error("bidir pull-up does not follow direction and data");

   property p_ext_reset_clears;
      @(posedge aclk)
      !ext_rst_n |-> !s_axi_bvalid && !s_axi_rvalid
                     && bidir_port_pins_out == 8'h00;
   endproperty
   a_ext_reset_clears: assert property (p_ext_reset_clears)
      else $error("pin reset did not clear the block");

   property p_bd_dir_write;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      (s_wr_both ##0 (s_axi_awaddr == tmp_pkg::OFF_BD_DIR && s_axi_wstrb[0]))
         ##1 1'b1 |=> bidir_port_pins_oe == $past(s_axi_wdata[7:0], 2)
                      && s_axi_bvalid;
   endproperty
   a_bd_dir_write: assert property (p_bd_dir_write)
      else $error("direction write did not reach the bidir enables");

   property p_wr_answer;
      @(posedge aclk) disable iff (!aresetn || !ext_rst_n)
      s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response not two cycles after the handshake");

endmodule : tmp_port_pins

// File: verification/tmp_pin_model.sv
// external circuitry model: resolves pin levels seen by the port block
module tmp_pin_model #(
   parameter int W = 8
) (
   // clock for the floating pattern
   input  wire logic         aclk,
   // block side of the pins
   input  wire logic [W-1:0] dut_out,
   input  wire logic [W-1:0] dut_oe,
   input  wire logic [W-1:0] dut_pu,
   // outside drivers
   input  wire logic [W-1:0] ext_val,
   input  wire logic [W-1:0] ext_en,
   // resolved level
   output      logic [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] spin_ff = '0;

   // an undriven, unpulled pin wanders so nothing can rely on it
   always @(posedge aclk) spin_ff <= ~spin_ff;

   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (dut_oe[i]) pin[i] = dut_out[i];
         else if (ext_en[i]) pin[i] = ext_val[i];
         else if (dut_pu[i]) pin[i] = 1'b1;
         else pin[i] = spin_ff[i];
      end
   end
endmodule : tmp_pin_model

// File: verification/tiny_mcu_port_pins_tb_top.sv
// self-checking bench for the port pin block over axi4-lite
module tiny_mcu_port_pins_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, ext_rst_n, run;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [2:0] mixed_port_pins_in, mixed_port_pins_out;
   logic [2:0] mixed_port_pins_oe, mixed_port_pins_pu;
   logic led_sink_pin_out, led_sink_pin_oe, led_sink_pin_hc;
   logic [7:0] input_port_pins_in, input_alt_en, input_port_pins_pu;
   logic [7:0] bidir_port_pins_in, bidir_port_pins_out;
   logic [7:0] bidir_port_pins_oe, bidir_port_pins_pu;
   int bad_count, cmp_count;
   logic [7:0] rw_off [5];
   logic [2:0] mix_ev, mix_ee;
   logic [7:0] in_ev, in_ee, bd_ev, bd_ee;

   tmp_port_pins DUT (.aclk, .aresetn, .ext_rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mixed_port_pins_in, .mixed_port_pins_out, .mixed_port_pins_oe,
      .mixed_port_pins_pu, .led_sink_pin_out, .led_sink_pin_oe,
      .led_sink_pin_hc, .input_port_pins_in, .input_alt_en,
      .input_port_pins_pu, .bidir_port_pins_in, .bidir_port_pins_out,
      .bidir_port_pins_oe, .bidir_port_pins_pu);

   // ---------------------------------------------------------------
   // outside world on the pins
   // ---------------------------------------------------------------
   tmp_pin_model #(.W(3)) u_mix (.aclk, .dut_out(mixed_port_pins_out),
      .dut_oe(mixed_port_pins_oe), .dut_pu(mixed_port_pins_pu),
      .ext_val(mix_ev), .ext_en(mix_ee), .pin(mixed_port_pins_in));
   tmp_pin_model u_in (.aclk, .dut_out(8'h00), .dut_oe(8'h00),
      .dut_pu(input_port_pins_pu), .ext_val(in_ev), .ext_en(in_ee),
      .pin(input_port_pins_in));
   tmp_pin_model u_bd (.aclk, .dut_out(bidir_port_pins_out),
      .dut_oe(bidir_port_pins_oe), .dut_pu(bidir_port_pins_pu),
      .ext_val(bd_ev), .ext_en(bd_ee), .pin(bidir_port_pins_in));

   initial begin
      aclk = 1'b0;
      forever #2 if (run) aclk = ~aclk;
   end

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
         bad_count++;
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 40) begin
         bad_count++;
         wrap_up();
      end
   endtask : tmo

   // ---------------------------------------------------------------
   // bus cycles, entered just after a rising edge
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int n;
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40 && !(aw && w); n++) begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      tmo(n);
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1) break;
      end
      tmo(n);
      chk(32'(s_axi_bresp), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) break;
      end
      tmo(n);
      s_axi_arvalid <= 1'b0;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1) break;
      end
      tmo(n);
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask : rd

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      run = 1'b1;
      aresetn = 1'b0;
      ext_rst_n = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;   // held high for the whole run
      s_axi_rready = 1'b1;
      input_alt_en = 8'h00;
      {mix_ev, mix_ee} = 6'h00;
      {in_ev, in_ee} = 16'h0A0F;
      {bd_ev, bd_ee} = 16'h000A;
      rw_off = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(32'(bidir_port_pins_oe), 32'h0);
      foreach (rw_off[i]) begin
         rd(rw_off[i], 32'h0, tmp_pkg::RESP_OKAY);
      end
      chk(32'(led_sink_pin_oe), 32'h1);
      // mixed port: inputs with pull-ups, bit 1 pulled low outside
      wr(tmp_pkg::OFF_MIX_DAT, 8'h0B, tmp_pkg::RESP_OKAY);
      mix_ee <= 3'h2;
      chk(32'(mixed_port_pins_pu), 32'h7);
      chk(32'(mixed_port_pins_oe), 32'h0);
      // pin levels need two synchroniser edges before readback
      repeat (2) @(posedge aclk);
      rd(tmp_pkg::OFF_MIX_PIN, 32'h09, tmp_pkg::RESP_OKAY);
      mix_ee <= 3'h0;
      wr(tmp_pkg::OFF_MIX_CTL, 8'h0F, tmp_pkg::RESP_OKAY);
      chk(32'({mixed_port_pins_oe, mixed_port_pins_pu}), 32'h38);
      chk(32'({led_sink_pin_hc, led_sink_pin_out}), 32'h2);
      wr(tmp_pkg::OFF_MIX_DAT, 8'h04, tmp_pkg::RESP_OKAY);
      chk(32'({mixed_port_pins_out, led_sink_pin_out}), 32'h1);
      repeat (2) @(posedge aclk);
      rd(tmp_pkg::OFF_MIX_PIN, 32'h00, tmp_pkg::RESP_OKAY);
      // input-only port: shared pull-up, overridden by alternate use
      wr(tmp_pkg::OFF_IN_CTL, 8'h01, tmp_pkg::RESP_OKAY);
      chk(32'(input_port_pins_pu), 32'hFF);
      repeat (2) @(posedge aclk);
      rd(tmp_pkg::OFF_IN_PIN, 32'hFA, tmp_pkg::RESP_OKAY);
      input_alt_en <= 8'h05;
      repeat (3) @(posedge aclk);
      chk(32'(input_port_pins_pu), 32'hFA);
      // bidirectional port: per-pin direction and pull-up
      wr(tmp_pkg::OFF_BD_DIR, 8'hF0, tmp_pkg::RESP_OKAY);
      wr(tmp_pkg::OFF_BD_DAT, 8'hA5, tmp_pkg::RESP_OKAY);
      chk(32'(bidir_port_pins_oe), 32'hF0);
      chk(32'(bidir_port_pins_pu), 32'h05);
      chk(32'(bidir_port_pins_out), 32'hA5);
      wr(tmp_pkg::OFF_BD_PIN, 8'h00, tmp_pkg::RESP_OKAY);
      rd(tmp_pkg::OFF_BD_PIN, 32'hA5, tmp_pkg::RESP_OKAY);
      // lane 0 not strobed: the write must leave the data alone
      s_axi_wstrb <= 4'h0;
      wr(tmp_pkg::OFF_BD_DAT, 8'h00, tmp_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(tmp_pkg::OFF_BD_DAT, 32'hA5, tmp_pkg::RESP_OKAY);
      wr(8'h20, 8'hFF, tmp_pkg::RESP_SLVERR);
      rd(8'h20, 32'h0, tmp_pkg::RESP_SLVERR);
      // external reset with the clock stopped
      #1 run = 1'b0;
      #2 ext_rst_n = 1'b0;
      #1 chk(32'({bidir_port_pins_oe, bidir_port_pins_pu}), 32'h0);
      chk(32'({mixed_port_pins_oe, led_sink_pin_oe}), 32'h0);
      chk(32'(input_port_pins_pu), 32'h0);
      #52 ext_rst_n = 1'b1;   // held past the minimum
      #1 run = 1'b1;
      repeat (2) @(posedge aclk);
      rd(tmp_pkg::OFF_BD_DAT, 32'h0, tmp_pkg::RESP_OKAY);
      // external reset with the clock running
      wr(tmp_pkg::OFF_BD_DIR, 8'h3C, tmp_pkg::RESP_OKAY);
      chk(32'(bidir_port_pins_oe), 32'h3C);
      ext_rst_n <= 1'b0;
      repeat (tmp_pkg::RST_MIN_CYC + 1) @(posedge aclk);
      chk(32'({bidir_port_pins_oe, mixed_port_pins_oe}), 32'h0);
      ext_rst_n <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(tmp_pkg::OFF_BD_DIR, 32'h0, tmp_pkg::RESP_OKAY);
      // bus reset in mid-run
      wr(tmp_pkg::OFF_BD_DIR, 8'h81, tmp_pkg::RESP_OKAY);
      chk(32'(bidir_port_pins_oe), 32'h81);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'(bidir_port_pins_oe), 32'h0);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(tmp_pkg::OFF_BD_DIR, 32'h0, tmp_pkg::RESP_OKAY);
      wrap_up();
   end
endmodule : tiny_mcu_port_pins_tb_top
